// ==== verilog/wwd_pkg.sv ====
package wwd_pkg;

	// Core clock rate in hertz.
	localparam longint CLK_HZ = 125_000_000;
	// Width of every window bound and of the window timer count; 77 s plus tolerance needs 34 bits.
	localparam int TIME_W = 40;

	// Factory window times with the timing pin floating, typical figures.
	localparam longint FLOAT_LOWER_MS = 800;
	localparam longint FLOAT_UPPER_MS = 1600;
	// Factory window times with the timing pin pulled up, typical figures.
	localparam longint RES_LOWER_US = 1850;
	localparam longint RES_UPPER_US = 11000;
	localparam longint FLOAT_LOWER_CYC = FLOAT_LOWER_MS * CLK_HZ / 1000;
	localparam longint FLOAT_UPPER_CYC = FLOAT_UPPER_MS * CLK_HZ / 1000;
	localparam longint RES_LOWER_CYC = RES_LOWER_US * CLK_HZ / 1_000_000;
	localparam longint RES_UPPER_CYC = RES_UPPER_US * CLK_HZ / 1_000_000;

	// Capacitor timing: slope in tenths of s per uF, charge source, trip level, offset.
	localparam longint CAP_SLOPE_X10 = 774;
	localparam longint CHARGE_NA = 375;
	localparam longint TRIP_MV = 1210;
	localparam longint CAP_OFFSET_MS = 55;
	localparam longint CAP_MAX_UF = 1;
	localparam longint CAP_OFFSET_CYC = CAP_OFFSET_MS * CLK_HZ / 1000;
	// Upper bound over charge time, in Q16 fixed point.
	localparam longint CAP_RATIO_Q16 = CAP_SLOPE_X10 * CHARGE_NA * 65536 / (10 * TRIP_MV);
	// Charge time of the largest capacitor, doubled as a give-up limit; uF times mV over nA is seconds.
	localparam longint CHARGE_LIMIT_CYC = 2 * CAP_MAX_UF * TRIP_MV * CLK_HZ / CHARGE_NA;

	// Reset value of the fault hold; the fault output stays low this many cycles plus one after a window violation.
	localparam logic [31:0] FAULT_HOLD_RST = 32'h0000_03E8;

	// Register byte offsets.
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MASK = 8'h04;
	localparam logic [7:0] REG_STATE = 8'h08;
	localparam logic [7:0] REG_HOLD = 8'h0C;
	localparam logic [7:0] REG_CHARGE = 8'h10;

	// Status and mask bit positions.
	localparam int ST_EARLY = 0;
	localparam int ST_LATE = 1;
	localparam int ST_MODE = 2;
	localparam int ST_RESET = 3;
	localparam int ST_W = 4;

	// Only whole-word writes are taken; reads are answered whatever their size.
	localparam logic [2:0] HSIZE_WORD = 3'h2;

	// Timing pin option reported by the pin sense logic.
	typedef enum logic [1:0]
	{
		WWD_MODE_FLOAT = 2'b00,
		WWD_MODE_RES = 2'b01,
		WWD_MODE_CAP = 2'b10
	} wwd_mode_t;

	// Watchdog sequencer states.
	typedef enum logic [4:0]
	{
		WWD_OFF = 5'b00001,
		WWD_MEASURE = 5'b00010,
		WWD_FIRST = 5'b00100,
		WWD_WINDOW = 5'b01000,
		WWD_FAULT = 5'b10000
	} wwd_state_t;

endpackage

// ==== verilog/wwd_sync.sv ====
`timescale 1ns/1ps

// Three-flop synchroniser; a bit changes once the second and third flops agree.
module wwd_sync #(
	parameter int W = 1
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Raw and filtered levels.
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	import wwd_pkg::*;

	// All state of the synchroniser.
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} wwd_sync_st_t;

	wwd_sync_st_t sy_reg;
	wwd_sync_st_t sy_next;

	if (W < 1)
	begin : g_chk
		$error("wwd_sync needs at least one bit");
	end

	// Only s2 reads s1; the agreement filter looks at s2 and s3 alone.
	always_comb
	begin
		sy_next = sy_reg;
		sy_next.s1 = d;
		sy_next.s2 = sy_reg.s1;
		sy_next.s3 = sy_reg.s2;
		sy_next.q = (sy_reg.s2 & sy_reg.s3) | (sy_reg.q & (sy_reg.s2 ^ sy_reg.s3));
	end

	// State register.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			sy_reg <= '0;
		else
			sy_reg <= sy_next;
	end

	assign q = sy_reg.q;
endmodule

// ==== verilog/wwd_cap_meter.sv ====
`timescale 1ns/1ps

// Times the charge of the timing capacitor and turns it into window bounds.
module wwd_cap_meter #(
	parameter longint LIMIT = wwd_pkg::CHARGE_LIMIT_CYC,
	parameter longint OFFSET = wwd_pkg::CAP_OFFSET_CYC
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Control from the sequencer.
	input wire logic start,
	input wire logic abort,
	// Pin comparator: high once the pin reaches its trip level.
	input wire logic level_reached,
	// Results.
	output logic charge_on,
	output logic done,
	output logic [31:0] charge_cyc,
	output logic [wwd_pkg::TIME_W-1:0] upper_cyc,
	output logic [wwd_pkg::TIME_W-1:0] lower_cyc
);
	import wwd_pkg::*;

	// All state of the meter.
	typedef struct packed {
		logic busy;
		logic done;
		logic [31:0] cnt;
		logic [TIME_W-1:0] upper;
	} wwd_cap_st_t;

	wwd_cap_st_t cm_reg;
	wwd_cap_st_t cm_next;

	if (LIMIT >= 64'h0000_0000_FFFF_FFFF)
	begin : g_chk
		$error("wwd_cap_meter limit does not fit the charge counter");
	end

	// Upper bound from charge time: slope over charge rate, plus the fixed offset.
	function automatic logic [TIME_W-1:0] cap_upper(input logic [31:0] c);
		logic [63:0] p;
		p = 64'(c) * 64'(CAP_RATIO_Q16);
		return TIME_W'(p >> 16) + TIME_W'(OFFSET);
	endfunction

	// The source stays on until the trip level or the give-up limit.
	always_comb
	begin
		cm_next = cm_reg;
		cm_next.done = 1'b0;
		if (abort)
			cm_next.busy = 1'b0;
		else if (start)
		begin
			cm_next.busy = 1'b1;
			cm_next.cnt = '0;
		end
		else if (cm_reg.busy)
		begin
			// An oversized capacitor never trips; the limit ends the wait.
			if (level_reached || cm_reg.cnt >= 32'(LIMIT))
			begin
				cm_next.busy = 1'b0;
				cm_next.done = 1'b1;
				cm_next.upper = cap_upper(cm_reg.cnt);
			end
			else
				cm_next.cnt = cm_reg.cnt + 32'h0000_0001;
		end
	end

	// State register.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			cm_reg <= '0;
		else
			cm_reg <= cm_next;
	end

	assign charge_on = cm_reg.busy;
	assign done = cm_reg.done;
	assign charge_cyc = cm_reg.cnt;
	assign upper_cyc = cm_reg.upper;
	// Lower bound is half of the upper one.
	assign lower_cyc = {1'b0, cm_reg.upper[TIME_W-1:1]};
endmodule

// ==== verilog/wwd_top.sv ====
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps

// What this block does
// - Reset held low between power-on and minimum
// - Fault output released while reset asserted
// - Above minimum, reset follows supply monitor
// - Floating pin: 800 ms lower, 1600 upper
// - Pulled-up pin: 1.85 ms lower, 11 upper
// - Factory timings kept at typical, within fifteen percent
// - Capacitor charged to trip level sets reference
// - Capacitor upper bound 77.4 s/uF plus 55 ms
// - Capacitor bounds scale; lower is half upper
// - Only falling pulse edges count
// - First pulse needs only beat upper bound
// - Later pulses outside window assert fault
// - Enable pin low disables, ignores pulses
module wwd_top #(
	parameter logic [wwd_pkg::TIME_W-1:0] FLOAT_LOWER = wwd_pkg::TIME_W'(wwd_pkg::FLOAT_LOWER_CYC),
	parameter logic [wwd_pkg::TIME_W-1:0] FLOAT_UPPER = wwd_pkg::TIME_W'(wwd_pkg::FLOAT_UPPER_CYC),
	parameter logic [wwd_pkg::TIME_W-1:0] RES_LOWER = wwd_pkg::TIME_W'(wwd_pkg::RES_LOWER_CYC),
	parameter logic [wwd_pkg::TIME_W-1:0] RES_UPPER = wwd_pkg::TIME_W'(wwd_pkg::RES_UPPER_CYC),
	parameter longint CAP_OFFSET = wwd_pkg::CAP_OFFSET_CYC,
	parameter longint CHARGE_LIMIT = wwd_pkg::CHARGE_LIMIT_CYC
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// Supply comparator results, asynchronous levels.
	input wire logic vdd_above_por_in,
	input wire logic vdd_above_min_in,
	input wire logic supply_ok_in,
	// Watchdog pins.
	input wire logic watchdog_pulse_in,
	input wire logic watchdog_enable_pin,
	// Timing pin sense, trip comparator and charge source.
	input wire logic [1:0] window_timing_pin_mode,
	input wire logic window_timing_pin_level,
	output logic window_timing_pin_charge,
	// Open-drain reset output.
	input wire logic reset_pin_i,
	output logic reset_pin_o,
	output logic reset_pin_oe_n,
	// Open-drain watchdog fault output.
	input wire logic watchdog_fault_out_i,
	output logic watchdog_fault_out_o,
	output logic watchdog_fault_out_oe_n,
	// Interrupt.
	output logic irq
);
	import wwd_pkg::*;

	// Synchronised pin bit positions.
	localparam int P_POR = 0;
	localparam int P_MIN = 1;
	localparam int P_OK = 2;
	localparam int P_PULSE = 3;
	localparam int P_EN = 4;
	localparam int P_LVL = 5;
	localparam int P_RST = 6;
	localparam int P_FLT = 7;
	localparam int P_MODE = 8;
	localparam int P_W = 10;

	// All state of the block.
	typedef struct packed {
		wwd_state_t state;
		logic [TIME_W-1:0] cnt;
		logic [31:0] hold_cnt;
		wwd_mode_t mode;
		logic mode_ok;
		logic rst_act;
		logic fault_drv;
		logic pulse_d;
		logic [ST_W-1:0] status;
		logic [ST_W-1:0] mask;
		logic [31:0] hold_reg;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic irq;
	} wwd_top_st_t;

	wwd_top_st_t top_reg;
	wwd_top_st_t top_next;

	// Synchronised pins.
	logic [P_W-1:0] pin_raw;
	logic [P_W-1:0] pin_q;
	// Capacitor meter hookup.
	logic meter_start;
	logic meter_done;
	logic [31:0] meter_charge;
	logic [TIME_W-1:0] cap_upper;
	logic [TIME_W-1:0] cap_lower;
	// Window bounds in force.
	logic [TIME_W-1:0] win_lower;
	logic [TIME_W-1:0] win_upper;
	// Supply decision, pulse edge and event strobes.
	logic rst_want;
	logic fall_edge;
	logic [ST_W-1:0] events;
	logic [ST_W-1:0] w1c;
	logic bus_sel;

	if (FLOAT_LOWER >= FLOAT_UPPER || RES_LOWER >= RES_UPPER || FLOAT_LOWER == '0 || RES_LOWER == '0)
	begin : g_chk
		$error("wwd_top lower window bounds must be nonzero and below the upper ones");
	end

	// Every outside level passes the three-flop filter.
	assign pin_raw = {window_timing_pin_mode, watchdog_fault_out_i, reset_pin_i, window_timing_pin_level,
		watchdog_enable_pin, watchdog_pulse_in, supply_ok_in, vdd_above_min_in, vdd_above_por_in};

	wwd_sync #(
		.W(P_W)
	) wwd_sync_i (
		.clock(clock),
		.rst(rst),
		.d(pin_raw),
		.q(pin_q)
	);

	// The meter is aborted by any reset so a new detection starts clean.
	wwd_cap_meter #(
		.LIMIT(CHARGE_LIMIT),
		.OFFSET(CAP_OFFSET)
	) wwd_cap_meter_i (
		.clock(clock),
		.rst(rst),
		.start(meter_start),
		.abort(top_reg.rst_act),
		.level_reached(pin_q[P_LVL]),
		.charge_on(window_timing_pin_charge),
		.done(meter_done),
		.charge_cyc(meter_charge),
		.upper_cyc(cap_upper),
		.lower_cyc(cap_lower)
	);

	// Window bounds for the pin option found at the last reset release.
	always_comb
	begin
		unique case (top_reg.mode)
			WWD_MODE_RES:
			begin
				// Pulled-up pin uses typical factory figures.
				win_lower = RES_LOWER;
				win_upper = RES_UPPER;
			end
			WWD_MODE_CAP:
			begin
				// Capacitor option uses the measured bounds.
				win_lower = cap_lower;
				win_upper = cap_upper;
			end
			default:
			begin
				// Floating pin, and the unused code, take the long factory window.
				win_lower = FLOAT_LOWER;
				win_upper = FLOAT_UPPER;
			end
		endcase
	end

	// Below the minimum the reset is held; above it the monitor decides alone.
	// Below power-on the output is undefined, so holding it asserted is safe.
	assign rst_want = ~pin_q[P_MIN] | ~pin_q[P_POR] | ~pin_q[P_OK];

	// Only a high-to-low change of the filtered pulse pin counts.
	assign fall_edge = top_reg.pulse_d & ~pin_q[P_PULSE];

	// Detection starts right after reset release when the pin shows a capacitor.
	assign meter_start = (top_reg.state == WWD_OFF) && !top_reg.rst_act && !top_reg.mode_ok &&
		(wwd_mode_t'(pin_q[P_MODE +: 2]) == WWD_MODE_CAP);

	// A register transfer is taken in its address phase.
	assign bus_sel = hsel && htrans[1] && hready;

	// Sequencer, register file and bus slave.
	always_comb
	begin
		top_next = top_reg;
		events = '0;
		w1c = '0;
		top_next.pulse_d = pin_q[P_PULSE];
		top_next.rst_act = rst_want;
		// A new reset assertion is reported once.
		if (rst_want && !top_reg.rst_act)
			events[ST_RESET] = 1'b1;

		unique case (top_reg.state)
			WWD_OFF:
			begin
				top_next.cnt = '0;
				if (!top_reg.rst_act && !top_reg.mode_ok)
				begin
					// Capture the pin option once per reset release.
					top_next.mode = wwd_mode_t'(pin_q[P_MODE +: 2]);
					if (meter_start)
						top_next.state = WWD_MEASURE;
					else
					begin
						top_next.mode_ok = 1'b1;
						events[ST_MODE] = 1'b1;
					end
				end
				else if (!top_reg.rst_act && pin_q[P_EN])
				begin
					// Enabling opens a fresh first window.
					top_next.state = WWD_FIRST;
				end
			end
			WWD_MEASURE:
			begin
				// Pulses are ignored while the charge is timed.
				if (meter_done)
				begin
					top_next.mode_ok = 1'b1;
					top_next.state = WWD_OFF;
					events[ST_MODE] = 1'b1;
				end
			end
			WWD_FIRST:
			begin
				// The first pulse has no lower bound to respect.
				if (fall_edge)
				begin
					top_next.state = WWD_WINDOW;
					top_next.cnt = '0;
				end
				else if (top_reg.cnt >= win_upper)
				begin
					top_next.state = WWD_FAULT;
					top_next.hold_cnt = '0;
					events[ST_LATE] = 1'b1;
				end
				else
					top_next.cnt = top_reg.cnt + TIME_W'(1);
			end
			WWD_WINDOW:
			begin
				if (fall_edge && top_reg.cnt < win_lower)
				begin
					// Too early: the window had not yet opened.
					top_next.state = WWD_FAULT;
					top_next.hold_cnt = '0;
					events[ST_EARLY] = 1'b1;
				end
				else if (fall_edge)
					top_next.cnt = '0;
				else if (top_reg.cnt >= win_upper)
				begin
					// Too late: the window closed with no pulse.
					top_next.state = WWD_FAULT;
					top_next.hold_cnt = '0;
					events[ST_LATE] = 1'b1;
				end
				else
					top_next.cnt = top_reg.cnt + TIME_W'(1);
			end
			WWD_FAULT:
			begin
				// Pulses during the fault are dropped; afterwards a new first window begins.
				if (top_reg.hold_cnt >= top_reg.hold_reg)
				begin
					top_next.state = WWD_FIRST;
					top_next.cnt = '0;
				end
				else
					top_next.hold_cnt = top_reg.hold_cnt + 32'h0000_0001;
			end
		endcase

		// Reset forces the watchdog off and asks for a new pin detection.
		if (top_reg.rst_act)
		begin
			top_next.state = WWD_OFF;
			top_next.mode_ok = 1'b0;
		end
		else if (!pin_q[P_EN] && top_reg.state != WWD_MEASURE)
		begin
			// Enable low stops the watchdog whatever the pulse pin does.
			if (top_reg.mode_ok || top_reg.state != WWD_OFF)
				top_next.state = WWD_OFF;
		end

		// The fault pin only pulls low in the fault state and never under reset.
		top_next.fault_drv = (top_next.state == WWD_FAULT) && !top_next.rst_act;

		// Address phase: note a word write, prepare a read answer.
		top_next.wr_pend = bus_sel && hwrite && (hsize == HSIZE_WORD);
		top_next.wr_addr = haddr[7:0];
		if (bus_sel && !hwrite)
		begin
			unique case (haddr[7:0])
				REG_STATUS: top_next.rdata = 32'(top_reg.status);
				REG_MASK: top_next.rdata = 32'(top_reg.mask);
				REG_STATE: top_next.rdata = 32'({pin_q[P_FLT], pin_q[P_RST], pin_q[P_EN], top_reg.fault_drv,
					top_reg.rst_act, top_reg.mode_ok, top_reg.mode, top_reg.state});
				REG_HOLD: top_next.rdata = top_reg.hold_reg;
				REG_CHARGE: top_next.rdata = meter_charge;
				default: top_next.rdata = 32'h0000_0000;
			endcase
		end

		// Data phase of a write.
		if (top_reg.wr_pend)
		begin
			unique case (top_reg.wr_addr)
				REG_STATUS: w1c = hwdata[ST_W-1:0];
				REG_MASK: top_next.mask = hwdata[ST_W-1:0];
				REG_HOLD: top_next.hold_reg = hwdata;
				default: ;
			endcase
		end

		// A new event wins over a clear written in the same cycle.
		top_next.status = (top_reg.status & ~w1c) | events;
		top_next.irq = |(top_next.status & top_next.mask);
	end

	// State register.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			top_reg <= '0;
			top_reg.state <= WWD_OFF;
			top_reg.mode <= WWD_MODE_FLOAT;
			top_reg.rst_act <= 1'b1;
			top_reg.hold_reg <= FAULT_HOLD_RST;
		end
		else
			top_reg <= top_next;
	end

	// Open-drain pins only ever pull low.
	assign reset_pin_o = 1'b0;
	assign reset_pin_oe_n = ~top_reg.rst_act;
	assign watchdog_fault_out_o = 1'b0;
	assign watchdog_fault_out_oe_n = ~top_reg.fault_drv;

	// Bus answers are always immediate and OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = top_reg.rdata;
	assign irq = top_reg.irq;
endmodule

// ==== bench/wwd_props.sv ====
`timescale 1ns/1ps

// Checks the supervisor outputs against the supply, pin and enable inputs.
// Each window on an input below allows for the three-flop input filter plus the output register.
module wwd_props (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Inputs watched.
	input wire logic vdd_above_por_in,
	input wire logic vdd_above_min_in,
	input wire logic supply_ok_in,
	input wire logic watchdog_enable_pin,
	input wire logic [1:0] window_timing_pin_mode,
	input wire logic window_timing_pin_level,
	// Outputs watched.
	input wire logic window_timing_pin_charge,
	input wire logic reset_pin_oe_n,
	input wire logic watchdog_fault_out_oe_n,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	AST_LOW_SUPPLY: assert property (!vdd_above_min_in [*8] |-> !reset_pin_oe_n)
		else $error("reset released below minimum supply");
	AST_FAULT_HIZ: assert property (!reset_pin_oe_n [*2] |-> watchdog_fault_out_oe_n)
		else $error("fault driven while reset asserted");
	AST_MONITOR_RESET: assert property ((vdd_above_min_in && !supply_ok_in) [*8] |-> !reset_pin_oe_n)
		else $error("reset released while monitor says low");
	AST_RESET_RELEASE: assert property ((vdd_above_por_in && vdd_above_min_in && supply_ok_in) [*8]
		|-> reset_pin_oe_n)
		else $error("reset held with good supply");
	AST_ENABLE_QUIET: assert property (!watchdog_enable_pin [*8] |-> watchdog_fault_out_oe_n)
		else $error("fault driven while watchdog disabled");
	AST_FAULT_HOLD: assert property ($fell(watchdog_fault_out_oe_n) |-> !watchdog_fault_out_oe_n [*8])
		else $error("fault pulse too short");
	AST_CHARGE_STOP: assert property (window_timing_pin_level [*6] |-> !window_timing_pin_charge)
		else $error("charge kept on after trip level");
	AST_CHARGE_MODE: assert property (window_timing_pin_charge |-> window_timing_pin_mode == 2'b10)
		else $error("charge on without capacitor option");
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus wait or error response");
	// Main scenarios: a fault, a capacitor charge, an interrupt.
	COV_FAULT: cover property ($fell(watchdog_fault_out_oe_n));
	COV_CHARGE: cover property ($rose(window_timing_pin_charge));
	COV_IRQ: cover property ($rose(irq));
endmodule

// ==== bench/wwd_mcu.sv ====
`timescale 1ns/1ps

// Processor model: each kick pulls the pulse line low for width cycles, then lets it rise.
module wwd_mcu (
	// Clock.
	input wire logic clock,
	// Command from the bench.
	input wire logic kick,
	input wire logic [7:0] width,
	// Pulse line toward the supervisor.
	output logic pulse_line
);
	logic [7:0] cnt;
	initial
	begin
		pulse_line = 1'b1;
		cnt = 8'h00;
	end
	// The line idles high so that every kick makes exactly one falling edge.
	always @(posedge clock)
	begin
		if (kick)
		begin
			pulse_line <= 1'b0;
			cnt <= width;
		end
		else if (cnt > 8'h01)
			cnt <= cnt - 8'h01;
		else
		begin
			pulse_line <= 1'b1;
			cnt <= 8'h00;
		end
	end
endmodule

// ==== bench/wwd_tb_top.sv ====
`timescale 1ns/1ps

// Self-checking bench; windows shortened to 40/80 cycles floating and 10/60 pulled up.
module wwd_tb_top;
	import wwd_pkg::*;
	localparam logic [31:0] ONE = 32'h0000_0001;
	localparam logic [31:0] ZERO = 32'h0000_0000;
	localparam int CAP_OFF = 20;
	logic clock, rst, hsel, hwrite, hready, hreadyout, hresp, irq, kick, fault_seen;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, window_timing_pin_mode;
	logic [2:0] hsize;
	logic [7:0] width;
	logic vdd_above_por_in, vdd_above_min_in, supply_ok_in, watchdog_pulse_in, watchdog_enable_pin;
	logic window_timing_pin_level, window_timing_pin_charge, reset_pin_o, reset_pin_oe_n;
	logic watchdog_fault_out_o, watchdog_fault_out_oe_n, rst_pin, fault_pin;
	int err_total, checked, n;
	longint up;
	// Both open-drain pins have pull-ups, so a released pin reads high.
	assign rst_pin = reset_pin_oe_n ? 1'b1 : reset_pin_o;
	assign fault_pin = watchdog_fault_out_oe_n ? 1'b1 : watchdog_fault_out_o;
	assign hready = hreadyout;
	wwd_top #(.FLOAT_LOWER(TIME_W'(40)), .FLOAT_UPPER(TIME_W'(80)), .RES_LOWER(TIME_W'(10)),
		.RES_UPPER(TIME_W'(60)), .CAP_OFFSET(CAP_OFF), .CHARGE_LIMIT(200)) wwd_top_i (.clock(clock), .rst(rst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.vdd_above_por_in(vdd_above_por_in), .vdd_above_min_in(vdd_above_min_in), .supply_ok_in(supply_ok_in),
		.watchdog_pulse_in(watchdog_pulse_in), .watchdog_enable_pin(watchdog_enable_pin),
		.window_timing_pin_mode(window_timing_pin_mode), .window_timing_pin_level(window_timing_pin_level),
		.window_timing_pin_charge(window_timing_pin_charge), .reset_pin_i(rst_pin), .reset_pin_o(reset_pin_o),
		.reset_pin_oe_n(reset_pin_oe_n), .watchdog_fault_out_i(fault_pin),
		.watchdog_fault_out_o(watchdog_fault_out_o), .watchdog_fault_out_oe_n(watchdog_fault_out_oe_n), .irq(irq));
	wwd_mcu wwd_mcu_i (.clock(clock), .kick(kick), .width(width), .pulse_line(watchdog_pulse_in));
	// Remembers any fault since the last reset; this process alone drives the flag.
	always @(posedge clock)
		fault_seen <= rst ? 1'b0 : (fault_seen | (fault_pin === 1'b0));
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clock);
	endtask
	// Waits for hready at a rising edge; only the bench watchdog ends a hang.
	task automatic wait_rdy();
		@(posedge clock);
		while (hready !== 1'b1)
			@(posedge clock);
	endtask
	// One single-word transfer: address phase, then data phase.
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		htrans <= 2'b10;
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic kick_once(input logic [7:0] w);
		kick <= 1'b1;
		width <= w;
		@(posedge clock);
		kick <= 1'b0;
	endtask
	task automatic wait_fault(input int lim);
		n = 0;
		while (fault_pin !== 1'b0 && n < lim)
		begin
			@(posedge clock);
			n++;
		end
	endtask
	task automatic do_reset(input logic [1:0] mode, input logic en);
		rst <= 1'b1;
		window_timing_pin_mode <= mode;
		watchdog_enable_pin <= en;
		window_timing_pin_level <= 1'b0;
		cyc(4);
		rst <= 1'b0;
		cyc(12);
	endtask
	task automatic t_supply();
		do_reset(2'b00, 1'b1);
		check("reset up", rst_pin, 1'b1);
		vdd_above_min_in <= 1'b0;
		repeat (3)
		begin
			kick_once(8'h02);
			cyc(3);
		end
		cyc(10);
		check("reset low", rst_pin, 1'b0);
		check("fault hiz", fault_pin, 1'b1);
		vdd_above_min_in <= 1'b1;
		supply_ok_in <= 1'b0;
		cyc(10);
		check("reset monitor", rst_pin, 1'b0);
		supply_ok_in <= 1'b1;
		cyc(10);
		check("reset release", rst_pin, 1'b1);
	endtask
	task automatic t_float();
		do_reset(2'b00, 1'b1);
		ahb(1'b1, REG_HOLD, 32'h0000_0014);
		ahb(1'b1, REG_MASK, ONE);
		kick_once(8'h04);
		cyc(60);
		kick_once(8'h14);
		cyc(60);
		kick_once(8'h14);
		cyc(30);
		check("no fault in window", fault_seen, 1'b0);
		kick_once(8'h02);
		wait_fault(12);
		check("early fault", fault_pin, 1'b0);
		cyc(2);
		check("irq early", irq, 1'b1);
		ahb(1'b0, REG_STATUS, ZERO);
		check("status early", 32'(rd[ST_EARLY]), ONE);
		cyc(25);
		check("fault ends", fault_pin, 1'b1);
		ahb(1'b1, REG_STATUS, ONE);
		ahb(1'b0, REG_STATUS, ZERO);
		check("status cleared", 32'(rd[ST_EARLY]), ZERO);
		check("irq cleared", irq, 1'b0);
	endtask
	task automatic t_res_late();
		do_reset(2'b01, 1'b1);
		kick_once(8'h02);
		wait_fault(100);
		check("late time", 32'(n >= 58 && n <= 72), ONE);
		ahb(1'b0, REG_STATUS, ZERO);
		check("status late", 32'(rd[ST_LATE]), ONE);
		check("status mode", 32'(rd[ST_MODE]), ONE);
		check("irq masked", irq, 1'b0);
		// Let the fault stand its full minimum before the reset cuts it short.
		cyc(8);
		supply_ok_in <= 1'b0;
		cyc(10);
		check("fault released", fault_pin, 1'b1);
		supply_ok_in <= 1'b1;
	endtask
	task automatic t_disable();
		do_reset(2'b11, 1'b0);
		repeat (10)
		begin
			kick_once(8'h02);
			cyc(5);
		end
		cyc(100);
		check("disabled quiet", fault_seen, 1'b0);
		ahb(1'b0, REG_STATE, ZERO);
		check("state off", 32'(rd[4:0]), ONE);
		check("mode code", 32'(rd[7:5]), 32'h0000_0007);
		ahb(1'b1, 8'h20, ONE);
		ahb(1'b0, 8'h20, ZERO);
		check("unmapped", rd, ZERO);
	endtask
	task automatic t_cap();
		do_reset(2'b10, 1'b1);
		cyc(88);
		check("charging", window_timing_pin_charge, 1'b1);
		window_timing_pin_level <= 1'b1; // A small in-range capacitor trips early.
		cyc(8);
		check("charge off", window_timing_pin_charge, 1'b0);
		ahb(1'b0, REG_CHARGE, ZERO);
		check("charge count", 32'(rd >= 85 && rd <= 110), ONE);
		up = longint'(rd) * CAP_RATIO_Q16 / 65536 + CAP_OFF;
		wait_fault(4000);
		check("cap upper", 32'(n >= up - 20 && n <= up + 4), ONE);
	endtask
	task automatic wrap_up();
		if (err_total == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#80000;
		err_total++;
		wrap_up();
	end
	initial
	begin
		rst = 1'b1;
		hsel = 1'b1;
		haddr = ZERO;
		hwrite = 1'b0;
		htrans = 2'b00;
		hsize = HSIZE_WORD;
		hwdata = ZERO;
		vdd_above_por_in = 1'b1;
		vdd_above_min_in = 1'b1;
		supply_ok_in = 1'b1;
		watchdog_enable_pin = 1'b0;
		window_timing_pin_mode = 2'b00;
		window_timing_pin_level = 1'b0;
		kick = 1'b0;
		width = 8'h02;
		err_total = 0;
		checked = 0;
		t_supply();
		t_float();
		t_res_late();
		t_disable();
		t_cap();
		wrap_up();
	end
endmodule

bind wwd_top wwd_props wwd_props_i (.clock(clock), .rst(rst), .vdd_above_por_in(vdd_above_por_in),
	.vdd_above_min_in(vdd_above_min_in), .supply_ok_in(supply_ok_in), .watchdog_enable_pin(watchdog_enable_pin),
	.window_timing_pin_mode(window_timing_pin_mode), .window_timing_pin_level(window_timing_pin_level),
	.window_timing_pin_charge(window_timing_pin_charge), .reset_pin_oe_n(reset_pin_oe_n),
	.watchdog_fault_out_oe_n(watchdog_fault_out_oe_n), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
